// [rtl/link_credit_pkg.sv]
// Shared constants, field layouts and carrier types for the credit and routing node
package link_credit_pkg;

  // Credit packet layout
  localparam logic [5:0] CREDIT_CMD     = 6'h37;
  localparam int         CMD_LSB        = 0;
  localparam int         LEN_BIT        = 6;
  localparam int         SET_LSB        = 8;
  localparam int         VENDOR_LSB     = 12;
  localparam int         CREDIT_LSB     = 16;
  localparam int         SHORT_ACK_LSB  = 24;
  localparam int         LONG_ACK_LSB   = 56;
  localparam logic [2:0] ALT_SET        = 3'h0;
  localparam logic [2:0] STREAM_SET     = 3'h2;
  localparam int         ALT_NUM        = 4;
  localparam int         STREAM_NUM     = 16;
  localparam int         CREDIT_W       = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] UNIT_OFS       = 8'h04;
  localparam logic [7:0] DIRECT_OFS     = 8'h08;
  localparam logic [7:0] OWN_BASE_OFS   = 8'h0C;
  localparam logic [7:0] OWN_LIMIT_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;
  localparam logic [7:0] STREAM_OFS     = 8'h20;
  localparam logic [7:0] STREAM_END_OFS = 8'h5C;

  // Control register fields
  localparam int CHAIN_END0_BIT  = 0;
  localparam int CHAIN_END1_BIT  = 1;
  localparam int INIT_DONE0_BIT  = 2;
  localparam int INIT_DONE1_BIT  = 3;
  localparam int DROP_UNINIT_BIT = 4;
  localparam int RETRY_EN_BIT    = 5;
  localparam int SUBTRACT_BIT    = 6;
  localparam int SET_EN_LSB      = 8;
  localparam int VEND_LSB        = 16;

  // Unit register fields
  localparam int OWN_UNIT_LSB    = 0;
  localparam int OWN_COUNT_LSB   = 5;
  localparam int HOST_CLUMP_LSB  = 10;

  // Reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_FF00;
  localparam logic [31:0] UNIT_RST      = 32'h0000_0021;
  localparam logic [31:0] DIRECT_RST    = 32'h0000_0000;
  localparam logic [31:0] OWN_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] OWN_LIMIT_RST = 32'h0000_0000;

  localparam logic [39:0] RESERVED_BASE = 40'hFD_0000_0000;

  typedef enum logic [1:0] {
    PKT_BROADCAST = 2'h1,
    PKT_DIRECTED  = 2'h2,
    PKT_RESPONSE  = 2'h3
  } pkt_kind_t;

  typedef struct packed {
    logic       valid;
    logic       longForm;
    logic [2:0] setSel;
    logic [31:0] credits;
    logic [7:0] ackPtr;
  } credit_req_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] bytes;
  } credit_pkt_t;

  typedef struct packed {
    logic        valid;
    logic        inLink;
    pkt_kind_t   kind;
    logic        nonposted;
    logic        isRead;
    logic        compat;
    logic        bridge;
    logic [4:0]  unit_identifier;
    logic [39:0] addr;
  } route_req_t;

  typedef struct packed {
    logic valid;
    logic accept;
    logic forward;
    logic outLink;
    logic pend;
    logic drop;
    logic abort;
    logic abortBridge;
    logic readOnes;
  } route_res_t;

endpackage : link_credit_pkg

// [rtl/link_credit_router.sv]
// Credit packet encode/decode, credit counters and packet routing decision
//
// How it works
// - Length bit zero gives four bytes, one gives eight bytes.
// - Command 110111b in byte 0; set-select field in byte 1.
// - Vendor side field comes from a register, zero when unused.
// - Retry acknowledge is used only when retry is enabled.
// - Alternate set uses short form; two-bit counts per channel.
// - Alternate posted and response counts free command and data together.
// - Stream set uses long form; sixteen two-bit counts.
// - Each count frees zero to three; further packets free more.
// - Broadcasts are posted only, host-originated, ended at chain end.
// - Broadcasts are accepted locally and also forwarded.
// - Host downstream request with compat clear and owned address is accepted.
// - Compat downstream requests go to the subtractive-decode node only.
// - Upstream request accepted if direct-route enabled, not reserved, owned.
// - Bridge responses with own unit are accepted; others forwarded.
// - Downstream packets are accepted from either link.
// - Forwarded packets leave on the opposite link.
// - Uninitialised outgoing link: requests pend or reject per drop control; responses are rejected.
// - Forwarding toward a chain-end link is rejected.
// - Clumped unit identifiers are treated as one.
// - Rejected broadcasts, posted requests and responses are dropped silently.
// - Rejected nonposted downstream gets master abort, bridge clear, ones.
// - Credit counters are at least four bits and saturate.
`timescale 1ns/100ps

module link_credit_router
  import link_credit_pkg::*;
#(
  parameter int CW = CREDIT_W
) (
  input  wire logic                            clock,
  input  wire logic                            reset,
  input  wire logic [7:0]                      regAddr,
  input  wire logic [31:0]                     regWrData,
  input  wire logic                            regWr,
  input  wire logic                            regRd,
  output logic      [31:0]                     regRdData,
  input  wire credit_req_t                     txReq,
  output credit_pkt_t                          txPkt,
  output logic                                 txRefused,
  input  wire credit_pkt_t                     rxPkt,
  output logic                                 rxAckValid,
  output logic      [7:0]                      rxAckPtr,
  input  wire logic [ALT_NUM-1:0]              altDebit,
  input  wire logic [STREAM_NUM-1:0]           streamDebit,
  output logic      [ALT_NUM-1:0][CW-1:0]      altCredit,
  output logic      [STREAM_NUM-1:0][CW-1:0]   streamCredit,
  input  wire route_req_t                      routeReq,
  output route_res_t                           routeRes
);

  localparam logic [CW+1:0] CREDIT_MAX = {2'b00, {CW{1'b1}}};

  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] unit_r;
  logic [31:0] direct_r;
  logic [31:0] ownBase_r;
  logic [31:0] ownLimit_r;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;

  // Control fields
  wire logic       chainEnd0  = ctrl_r[CHAIN_END0_BIT];
  wire logic       chainEnd1  = ctrl_r[CHAIN_END1_BIT];
  wire logic       initDone0  = ctrl_r[INIT_DONE0_BIT];
  wire logic       initDone1  = ctrl_r[INIT_DONE1_BIT];
  wire logic       dropUninit = ctrl_r[DROP_UNINIT_BIT];
  wire logic       retryEn    = ctrl_r[RETRY_EN_BIT];
  wire logic       subtract   = ctrl_r[SUBTRACT_BIT];
  wire logic [7:0] setEnable  = ctrl_r[SET_EN_LSB +: 8];
  wire logic [3:0] vendorSide = ctrl_r[VEND_LSB +: 4];
  wire logic [4:0] ownUnit    = unit_r[OWN_UNIT_LSB +: 5];
  wire logic [4:0] ownCount   = unit_r[OWN_COUNT_LSB +: 5];
  wire logic [4:0] hostClump  = unit_r[HOST_CLUMP_LSB +: 5];

  // Register write decode
  wire logic wrCtrl     = regWr && (regAddr == CTRL_OFS);
  wire logic wrUnit     = regWr && (regAddr == UNIT_OFS);
  wire logic wrDirect   = regWr && (regAddr == DIRECT_OFS);
  wire logic wrOwnBase  = regWr && (regAddr == OWN_BASE_OFS);
  wire logic wrOwnLimit = regWr && (regAddr == OWN_LIMIT_OFS);

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r     <= CTRL_RST;
      unit_r     <= UNIT_RST;
      direct_r   <= DIRECT_RST;
      ownBase_r  <= OWN_BASE_RST;
      ownLimit_r <= OWN_LIMIT_RST;
    end else begin
      if (wrCtrl)     ctrl_r     <= regWrData & 32'h000F_FF7F;
      if (wrUnit)     unit_r     <= regWrData & 32'h0000_7FFF;
      if (wrDirect)   direct_r   <= regWrData;
      if (wrOwnBase)  ownBase_r  <= regWrData;
      if (wrOwnLimit) ownLimit_r <= regWrData;
    end
  end

  // Read selection
  wire logic       rdStream   = (regAddr >= STREAM_OFS) && (regAddr <= STREAM_END_OFS);
  wire logic [3:0] streamIdx  = 4'((regAddr - STREAM_OFS) >> 2);
  wire logic [31:0] altStatus = 32'(altCredit);
  wire logic [31:0] streamRd  = 32'(streamCredit[streamIdx]);

  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        CTRL_OFS:      rdData_nxt = ctrl_r;
        UNIT_OFS:      rdData_nxt = unit_r;
        DIRECT_OFS:    rdData_nxt = direct_r;
        OWN_BASE_OFS:  rdData_nxt = ownBase_r;
        OWN_LIMIT_OFS: rdData_nxt = ownLimit_r;
        STATUS_OFS:    rdData_nxt = altStatus;
        default:       rdData_nxt = rdStream ? streamRd : 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) rdData_r <= 32'h0000_0000;
    else       rdData_r <= rdData_nxt;
  end

  assign regRdData = rdData_r;

  // ---------------- Credit packet encoder ----------------
  // set must be enabled
  wire logic txAllowed = setEnable[txReq.setSel];
  wire logic txLong    = (txReq.setSel == STREAM_SET) ? 1'b1 :
                         (txReq.setSel == ALT_SET) ? 1'b0 : txReq.longForm;
  wire logic [7:0] txAck = retryEn ? txReq.ackPtr : 8'h00;
  wire logic [7:0] txByte0 = {1'b0, txLong, CREDIT_CMD};
  wire logic [7:0] txByte1 = {vendorSide, 1'b0, txReq.setSel};
  // short form carries one credit byte
  wire logic [63:0] txShort = {32'h0000_0000, txAck, txReq.credits[7:0], txByte1, txByte0};
  wire logic [63:0] txLongW = {txAck, 8'h00, txReq.credits, txByte1, txByte0};
  wire credit_pkt_t txPkt_nxt = '{valid: txReq.valid && txAllowed,
                                  bytes: (txReq.valid && txAllowed) ?
                                         (txLong ? txLongW : txShort) : 64'h0};

  credit_pkt_t txPkt_r;
  logic        txRefused_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      txPkt_r     <= '0;
      txRefused_r <= 1'b0;
    end else begin
      txPkt_r     <= txPkt_nxt;
      txRefused_r <= txReq.valid && !txAllowed;
    end
  end

  assign txPkt     = txPkt_r;
  assign txRefused = txRefused_r;

  // ---------------- Credit packet decoder ----------------
  // command match; reserved bits ignored
  wire logic [2:0] rxSet   = rxPkt.bytes[SET_LSB +: 3];
  wire logic       rxLen   = rxPkt.bytes[LEN_BIT];
  wire logic       rxHit   = rxPkt.valid && (rxPkt.bytes[CMD_LSB +: 6] == CREDIT_CMD);
  wire logic       rxAlt    = rxHit && (rxSet == ALT_SET) && !rxLen;
  wire logic       rxStream = rxHit && (rxSet == STREAM_SET) && rxLen;
  wire logic [31:0] rxCredits = rxPkt.bytes[CREDIT_LSB +: 32];
  wire logic [7:0] rxAckSel = rxLen ? rxPkt.bytes[LONG_ACK_LSB +: 8] :
                                      rxPkt.bytes[SHORT_ACK_LSB +: 8];

  logic       rxAckValid_r;
  logic [7:0] rxAckPtr_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      rxAckValid_r <= 1'b0;
      rxAckPtr_r   <= 8'h00;
    end else begin
      rxAckValid_r <= rxHit && retryEn;
      rxAckPtr_r   <= (rxHit && retryEn) ? rxAckSel : 8'h00;
    end
  end

  assign rxAckValid = rxAckValid_r;
  assign rxAckPtr   = rxAckPtr_r;

  // ---------------- Saturating credit counters ----------------
  logic [ALT_NUM-1:0][CW-1:0]    altCredit_r;
  logic [STREAM_NUM-1:0][CW-1:0] streamCredit_r;

  genvar gi;
  generate
    for (gi = 0; gi < STREAM_NUM; gi++) begin : g_stream
      wire logic [CW+1:0] inc = rxStream ? (CW+2)'(rxCredits[2*gi +: 2]) : '0;
      wire logic [CW+1:0] cur = (CW+2)'(streamCredit_r[gi]);
      wire logic [CW+1:0] dec = (streamDebit[gi] && (cur != '0)) ? (CW+2)'(1) : '0;
      wire logic [CW+1:0] sum = cur + inc - dec;
      wire logic [CW-1:0] nxt = (sum > CREDIT_MAX) ? {CW{1'b1}} : sum[CW-1:0];
      always_ff @(posedge clock) begin
        if (reset) streamCredit_r[gi] <= '0;
        else       streamCredit_r[gi] <= nxt;
      end
    end
    for (gi = 0; gi < ALT_NUM; gi++) begin : g_alt
      // one count frees command and data alike
      wire logic [CW+1:0] inc = rxAlt ? (CW+2)'(rxCredits[2*gi +: 2]) : '0;
      wire logic [CW+1:0] cur = (CW+2)'(altCredit_r[gi]);
      wire logic [CW+1:0] dec = (altDebit[gi] && (cur != '0)) ? (CW+2)'(1) : '0;
      wire logic [CW+1:0] sum = cur + inc - dec;
      wire logic [CW-1:0] nxt = (sum > CREDIT_MAX) ? {CW{1'b1}} : sum[CW-1:0];
      always_ff @(posedge clock) begin
        if (reset) altCredit_r[gi] <= '0;
        else       altCredit_r[gi] <= nxt;
      end
    end
  endgenerate

  assign altCredit    = altCredit_r;
  assign streamCredit = streamCredit_r;

  // ---------------- Routing decision ----------------
  // clumped host identifiers count as unit 0
  wire logic [5:0] hostTop   = 6'(hostClump) + 6'h01;
  wire logic       fromHost  = 6'(routeReq.unit_identifier) < hostTop;
  // clumped own identifiers count as one
  wire logic [5:0] ownTop    = 6'(ownUnit) + 6'(ownCount);
  wire logic       ownsUnit  = (routeReq.unit_identifier >= ownUnit) &&
                               (6'(routeReq.unit_identifier) < ownTop);
  wire logic [31:0] addrHi   = routeReq.addr[39:8];
  wire logic       ownsAddr  = (addrHi >= ownBase_r) && (addrHi <= ownLimit_r);
  wire logic       reserved  = routeReq.addr >= RESERVED_BASE;
  wire logic       isBcast   = routeReq.kind == PKT_BROADCAST;
  wire logic       isDirReq  = routeReq.kind == PKT_DIRECTED;
  wire logic       isResp    = routeReq.kind == PKT_RESPONSE;
  wire logic       downReq   = isDirReq && fromHost;
  wire logic       upReq     = isDirReq && !fromHost;

  // host request to owned address, either link
  wire logic acceptDown   = downReq && !routeReq.compat && ownsAddr;
  wire logic acceptCompat = downReq && routeReq.compat && subtract;
  wire logic acceptUp     = upReq && direct_r[routeReq.unit_identifier] && !reserved && ownsAddr;
  wire logic acceptResp   = isResp && routeReq.bridge && ownsUnit;
  wire logic acceptAny    = isBcast || acceptDown || acceptCompat || acceptUp || acceptResp;
  wire logic wantForward  = isBcast || (!acceptAny && routeReq.kind != 2'h0);

  wire logic outLink      = !routeReq.inLink;
  wire logic outChainEnd  = outLink ? chainEnd1 : chainEnd0;
  wire logic outInitDone  = outLink ? initDone1 : initDone0;
  wire logic uninit       = !outChainEnd && !outInitDone;
  wire logic isRequest    = isBcast || isDirReq;
  wire logic pendIt       = wantForward && isRequest && uninit && !dropUninit;
  // reject toward chain end, or uninit link when dropping or for responses
  wire logic rejectIt     = wantForward && (outChainEnd || (uninit && (dropUninit || !isRequest)));
  wire logic silentDrop   = rejectIt && (isBcast || isResp || !routeReq.nonposted);
  // master abort reply for nonposted request
  wire logic abortIt      = rejectIt && isDirReq && routeReq.nonposted;

  wire route_res_t routeRes_nxt = '{
    valid:       routeReq.valid,
    accept:      routeReq.valid && acceptAny,
    forward:     routeReq.valid && wantForward && !rejectIt && !pendIt,
    outLink:     routeReq.valid && outLink,
    pend:        routeReq.valid && pendIt,
    drop:        routeReq.valid && silentDrop,
    abort:       routeReq.valid && abortIt,
    abortBridge: routeReq.valid && abortIt && upReq,
    readOnes:    routeReq.valid && abortIt && routeReq.isRead
  };

  route_res_t routeRes_r;

  always_ff @(posedge clock) begin
    if (reset) routeRes_r <= '0;
    else       routeRes_r <= routeRes_nxt;
  end

  assign routeRes = routeRes_r;

endmodule : link_credit_router

// [sim/link_neighbour_model.sv]
// Neighbour node that sends credit packets toward the block
`timescale 1ns/100ps

module link_neighbour_model
  import link_credit_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        send,
  input  wire logic        longForm,
  input  wire logic [2:0]  setSel,
  input  wire logic [31:0] credits,
  input  wire logic [7:0]  ackPtr,
  output credit_pkt_t      pkt
);
  logic [63:0] last = '0;
  wire logic [15:0] head = {4'h0, 1'b0, setSel, 1'b0, longForm, CREDIT_CMD};
  wire logic [63:0] frame = longForm ? {ackPtr, 8'h00, credits, head}
                                     : {32'h0, ackPtr, credits[7:0], head};

  // Idle bytes hold the inverse of the last frame so stale data is never mistaken
  always @(posedge clock) begin
    pkt.valid <= send;
    pkt.bytes <= send ? frame : ~last;
    if (send) begin
      last <= frame;
    end
  end
endmodule : link_neighbour_model

// [sim/link_credit_asserts.sv]
// Port checks for the credit and routing node
`timescale 1ns/100ps

module link_credit_asserts
  import link_credit_pkg::*;
#(
  parameter int CW = CREDIT_W
) (
  input wire logic                       clock,
  input wire logic                       reset,
  input wire credit_req_t                txReq,
  input wire credit_pkt_t                txPkt,
  input wire logic                       txRefused,
  input wire logic                       rxAckValid,
  input wire logic [7:0]                 rxAckPtr,
  input wire logic [ALT_NUM-1:0]         altDebit,
  input wire logic [ALT_NUM-1:0][CW-1:0] altCredit,
  input wire route_req_t                 routeReq,
  input wire route_res_t                 routeRes
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic [63:0] pb = txPkt.bytes;

  a_answer_once: assert property (txReq.valid |=> txPkt.valid != txRefused)
    else $error("credit request not answered once");
  a_short_len: assert property (txPkt.valid && !pb[LEN_BIT] |-> pb[63:32] == 32'h0)
    else $error("short credit packet has upper bytes");
  a_cmd_code: assert property (txPkt.valid |-> pb[5:0] == CREDIT_CMD)
    else $error("credit packet command wrong");
  a_alt_short: assert property (txReq.valid && txReq.setSel == ALT_SET |=>
    !txPkt.valid || (!pb[LEN_BIT] && pb[10:8] == ALT_SET)) else $error("alt set not short");
  a_stream_long: assert property (txReq.valid && txReq.setSel == STREAM_SET |=>
    !txPkt.valid || (pb[LEN_BIT] && pb[10:8] == STREAM_SET)) else $error("stream not long");
  a_rsvd_zero: assert property (txPkt.valid |->
    !pb[7] && !pb[11] && (!pb[LEN_BIT] || pb[55:48] == 8'h0)) else $error("reserved set");
  a_count_pass: assert property (txReq.valid |=>
    !txPkt.valid || pb[23:16] == $past(txReq.credits[7:0])) else $error("count byte wrong");
  a_ack_idle: assert property (!rxAckValid |-> rxAckPtr == 8'h0)
    else $error("ack pointer without ack");
  a_fwd_opposite: assert property (routeRes.valid && routeRes.forward |->
    routeRes.outLink != $past(routeReq.inLink)) else $error("forward on same link");
  a_bcast_accept: assert property (routeReq.valid && routeReq.kind == PKT_BROADCAST |=>
    routeRes.valid && routeRes.accept) else $error("broadcast not accepted");
  a_resp_silent: assert property (routeReq.valid && routeReq.kind == PKT_RESPONSE |=>
    !routeRes.abort && !routeRes.pend) else $error("response answered or held");
  a_credit_sat: assert property (altCredit[0] == {CW{1'b1}} && !altDebit[0] |=>
    altCredit[0] == {CW{1'b1}}) else $error("credit counter wrapped");

  c_long_pkt: cover property (txPkt.valid && pb[LEN_BIT]);
  c_abort: cover property (routeRes.valid && routeRes.abort);
  c_sat: cover property (altCredit[0] == {CW{1'b1}});
endmodule : link_credit_asserts

bind link_credit_router link_credit_asserts #(.CW(CW)) link_credit_asserts_inst (
  .clock(clock), .reset(reset), .txReq(txReq), .txPkt(txPkt), .txRefused(txRefused),
  .rxAckValid(rxAckValid), .rxAckPtr(rxAckPtr), .altDebit(altDebit),
  .altCredit(altCredit), .routeReq(routeReq), .routeRes(routeRes));

// [sim/tb.sv]
// Self-checking bench for the credit and routing node
`timescale 1ns/100ps

module tb
  import link_credit_pkg::*;
;
  typedef struct packed {logic [2:0] s; logic lf; logic [31:0] c; logic [7:0] ak;} txrow_t;
  typedef struct packed {route_req_t q; route_res_t e;} rrow_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = '0;
  logic [31:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sSend = 1'b0;
  logic sLong = 1'b0;
  logic [2:0] sSet = '0;
  logic [31:0] sCred = '0;
  logic [7:0] sAck = '0;
  logic [3:0] altDebit = '0;
  logic [15:0] streamDebit = '0;
  credit_req_t txReq = '0;
  route_req_t routeReq = '0;
  logic [31:0] regRdData;
  credit_pkt_t txPkt;
  credit_pkt_t rxPkt;
  logic txRefused;
  logic rxAckValid;
  logic [7:0] rxAckPtr;
  logic [3:0][3:0] altCredit;
  logic [15:0][3:0] streamCredit;
  route_res_t routeRes;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  txrow_t tr[4];
  rrow_t rt[10];

  link_credit_router link_credit_router_inst (
    .clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txReq(txReq), .txPkt(txPkt),
    .txRefused(txRefused), .rxPkt(rxPkt), .rxAckValid(rxAckValid), .rxAckPtr(rxAckPtr),
    .altDebit(altDebit), .streamDebit(streamDebit), .altCredit(altCredit),
    .streamCredit(streamCredit), .routeReq(routeReq), .routeRes(routeRes));
  link_neighbour_model link_neighbour_model_inst (
    .clock(clock), .send(sSend), .longForm(sLong), .setSel(sSet), .credits(sCred),
    .ackPtr(sAck), .pkt(rxPkt));

  always #5 clock = ~clock;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd

  task automatic tx(input txrow_t r);
    @(posedge clock);
    txReq <= '{1'b1, r.lf, r.s, r.c, r.ak};
    @(posedge clock);
    txReq.valid <= 1'b0;
    #1;
  endtask : tx

  task automatic rx(input logic [2:0] s, input logic lf, input logic [31:0] c);
    @(posedge clock);
    sSend <= 1'b1;
    sSet <= s;
    sLong <= lf;
    sCred <= c;
    @(posedge clock);
    sSend <= 1'b0;
    @(posedge clock);
    #1;
  endtask : rx

  task automatic route(input route_req_t r);
    @(posedge clock);
    routeReq <= r;
    @(posedge clock);
    routeReq.valid <= 1'b0;
    #1;
  endtask : route

  function automatic logic [63:0] expPkt(input txrow_t r, input logic [3:0] v);
    logic ln;
    ln = (r.s == STREAM_SET) || (r.s != ALT_SET && r.lf);
    expPkt = {ln ? {r.ak, 8'h00, r.c} : {32'h0, r.ak, r.c[7:0]}, v, 1'b0, r.s, 1'b0, ln, 6'h37};
  endfunction : expPkt

  function automatic route_req_t rq(input pkt_kind_t k, input logic l, input logic np,
      input logic rdf, input logic cp, input logic br, input logic [4:0] u,
      input logic [39:0] a);
    rq = '{1'b1, l, k, np, rdf, cp, br, u, a};
  endfunction : rq

  function automatic route_res_t rs(input logic a, input logic f, input logic l);
    rs = '{1'b1, a, f, ~l, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  endfunction : rs

  initial begin
    tr = '{'{3'h0, 1'b1, 32'hA5A5_A51B, 8'h3C}, '{3'h2, 1'b0, 32'h1234_5678, 8'hC3},
           '{3'h1, 1'b0, 32'h0000_00E4, 8'h01}, '{3'h7, 1'b1, 32'hFEDC_BA98, 8'hFF}};
    rt[0] = '{rq(PKT_BROADCAST, 0, 0, 0, 0, 0, 5'h00, 40'h0), rs(1, 1, 0)};
    rt[1] = '{rq(PKT_DIRECTED, 0, 1, 0, 0, 0, 5'h00, 40'h10_0040), rs(1, 0, 0)};
    rt[2] = '{rq(PKT_DIRECTED, 0, 1, 0, 0, 0, 5'h00, 40'h30_0000), rs(0, 1, 0)};
    rt[3] = '{rq(PKT_DIRECTED, 0, 0, 0, 1, 0, 5'h00, 40'h10_0040), rs(0, 1, 0)};
    rt[4] = '{rq(PKT_DIRECTED, 1, 0, 0, 0, 0, 5'h03, 40'h10_0040), rs(1, 0, 1)};
    rt[5] = '{rq(PKT_DIRECTED, 1, 0, 0, 0, 0, 5'h02, 40'h10_0040), rs(0, 1, 1)};
    rt[6] = '{rq(PKT_RESPONSE, 0, 0, 0, 0, 1, 5'h01, 40'h0), rs(1, 0, 0)};
    rt[7] = '{rq(PKT_RESPONSE, 0, 0, 0, 0, 1, 5'h04, 40'h0), rs(0, 1, 0)};
    rt[8] = '{rq(PKT_RESPONSE, 1, 0, 0, 0, 0, 5'h01, 40'h0), rs(0, 1, 1)};
    rt[9] = '{rq(PKT_DIRECTED, 1, 0, 0, 0, 0, 5'h00, 40'h10_0040), rs(1, 0, 1)};
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(CTRL_OFS, CTRL_RST);
    rd(UNIT_OFS, UNIT_RST);
    rd(8'hF0, 32'h0);
    wr(CTRL_OFS, 32'h0005_FF2C);
    foreach (tr[i]) begin
      tx(tr[i]);
      chk({txRefused, txPkt}, {2'b01, expPkt(tr[i], 4'h5)});
    end
    wr(CTRL_OFS, 32'h0000_FD0C);
    tx(tr[2]);
    chk({txRefused, txPkt.valid}, 2'b10);
    tx(tr[3]);
    chk(txPkt, {1'b1, expPkt('{3'h7, 1'b1, 32'hFEDC_BA98, 8'h00}, 4'h0)});
    wr(CTRL_OFS, 32'h0000_FF2C);
    sAck <= 8'hC3;
    rx(ALT_SET, 1'b1, 32'h3);
    chk({rxAckValid, rxAckPtr, altCredit}, {9'h1C3, 16'h0000});
    rx(ALT_SET, 1'b0, 32'h1B);
    chk({rxAckValid, rxAckPtr, altCredit}, {9'h1C3, 16'h0123});
    rx(STREAM_SET, 1'b1, 32'hE4E4_E4E4);
    chk(streamCredit, 64'h3210_3210_3210_3210);
    @(posedge clock);
    streamDebit <= 16'h0003;
    @(posedge clock);
    streamDebit <= 16'h0000;
    #1 chk(streamCredit, 64'h3210_3210_3210_3200);
    repeat (5) rx(ALT_SET, 1'b0, 32'hFF);
    chk(altCredit, 16'hFFFF);
    @(posedge clock);
    altDebit <= 4'h1;
    @(posedge clock);
    altDebit <= 4'h0;
    #1 chk(altCredit, 16'hFFFE);
    wr(CTRL_OFS, 32'h0000_FF0C);
    rx(ALT_SET, 1'b0, 32'h0);
    chk({rxAckValid, rxAckPtr}, 9'h000);
    wr(OWN_BASE_OFS, 32'h0000_1000);
    wr(OWN_LIMIT_OFS, 32'h0000_1FFF);
    wr(DIRECT_OFS, 32'h0000_0008);
    foreach (rt[i]) begin
      route(rt[i].q);
      chk(routeRes, rt[i].e);
    end
    wr(CTRL_OFS, 32'h0000_FF4C);
    route(rt[3].q);
    chk(routeRes, rs(1, 0, 0));
    wr(CTRL_OFS, 32'h0000_FF0E);
    route(rq(PKT_DIRECTED, 0, 1, 1, 0, 0, 5'h00, 40'h30_0000));
    chk(routeRes, 9'h125);
    route(rt[0].q);
    chk({routeRes.accept, routeRes.forward}, 2'b10);
    route(rq(PKT_DIRECTED, 0, 0, 0, 0, 0, 5'h00, 40'h30_0000));
    chk({routeRes.drop, routeRes.abort, routeRes.forward}, 3'b100);
    wr(CTRL_OFS, 32'h0000_FF0D);
    route(rq(PKT_DIRECTED, 1, 1, 0, 0, 0, 5'h02, 40'h10_0040));
    chk(routeRes, 9'h106);
    wr(CTRL_OFS, 32'h0000_FF00);
    route(rq(PKT_DIRECTED, 0, 0, 0, 0, 0, 5'h00, 40'h30_0000));
    chk({routeRes.pend, routeRes.drop}, 2'b10);
    wr(CTRL_OFS, 32'h0000_FF10);
    route(rq(PKT_DIRECTED, 0, 0, 0, 0, 0, 5'h00, 40'h30_0000));
    chk({routeRes.pend, routeRes.drop}, 2'b01);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    rd(CTRL_OFS, CTRL_RST);
    end_sim();
  end
endmodule : tb
